// ===== src/uifc_pkg.sv
// Package of register offsets, field positions, reset values and carriers for the USB interface control block
package uifc_pkg;

	// Peripheral number under which the register set is reached
	localparam logic [7:0] UIFC_PERIPH_NUM = 8'h01;

	// Register byte offsets
	localparam logic [7:0] UIFC_OFS_SOFT_RESET = 8'h00;
	localparam logic [7:0] UIFC_OFS_MODES = 8'h04;
	localparam logic [7:0] UIFC_OFS_DEV_ADDR = 8'h08;
	localparam logic [7:0] UIFC_OFS_FUNC_CTRL = 8'h0C;
	localparam logic [7:0] UIFC_OFS_OTG_CTRL = 8'h10;
	localparam logic [7:0] UIFC_OFS_OTG_STATUS = 8'h14;
	localparam logic [7:0] UIFC_OFS_SERIAL = 8'h18;
	localparam logic [7:0] UIFC_OFS_FLAGS = 8'h1C;
	localparam logic [7:0] UIFC_OFS_HOLD_MASK = 8'h20;
	localparam logic [7:0] UIFC_OFS_PORT_MASKS = 8'h24;
	localparam logic [7:0] UIFC_OFS_FRAME_NUM = 8'h28;
	localparam logic [7:0] UIFC_OFS_LAST_PID = 8'h2C;
	localparam logic [7:0] UIFC_OFS_LAST_EP = 8'h30;
	localparam logic [7:0] UIFC_OFS_EP_MARK = 8'h34;
	localparam logic [7:0] UIFC_OFS_OTG_FMASK = 8'h38;
	localparam logic [7:0] UIFC_OFS_POWER_SIG = 8'h3C;
	localparam logic [7:0] UIFC_OFS_PHY_MISC = 8'h40;

	// Widths of the writable fields and number of flag ports
	localparam int UIFC_MODES_W = 8;
	localparam int UIFC_ADDR_W = 7;
	localparam int UIFC_FLAG_W = 7;
	localparam int UIFC_PORTS = 4;

	// Writable-bit masks, reserved bits clear
	localparam logic [7:0] UIFC_MODES_WMASK = 8'hF7;
	localparam logic [7:0] UIFC_OTG_WMASK = 8'hDF;
	localparam logic [31:0] UIFC_FRAME_WMASK = 32'h0000_07FF;
	localparam logic [31:0] UIFC_EP_MARK_WMASK = 32'h0000_FFFF;
	localparam logic [31:0] UIFC_POWER_WMASK = 32'h0000_01FF;
	localparam logic [31:0] UIFC_PHY_WMASK = 32'h0004_3FF0;

	// Mode-control bit positions
	localparam int UIFC_MODE_TOKEN_PROCESS = 0;
	localparam int UIFC_MODE_TOKEN_CHECK = 1;
	localparam int UIFC_MODE_LINE_DECODE = 2;
	localparam int UIFC_MODE_IF_TIMING = 4;
	localparam int UIFC_MODE_POWER_SIG = 5;
	localparam int UIFC_MODE_SOF_TOKEN = 6;
	localparam int UIFC_MODE_EVENT_ACK = 7;

	// Functional-control field positions
	localparam int UIFC_FC_XCVR_BIT = 0;
	localparam int UIFC_FC_TERM_BIT = 1;
	localparam int UIFC_FC_OPMODE_LSB = 2;

	// Serial-control field positions
	localparam int UIFC_SC_FSLS_BIT = 0;
	localparam int UIFC_SC_TXEN_N_BIT = 1;
	localparam int UIFC_SC_TXDAT_BIT = 2;
	localparam int UIFC_SC_TXSE0_BIT = 3;
	localparam int UIFC_SC_RXDP_BIT = 4;
	localparam int UIFC_SC_RXDM_BIT = 5;
	localparam int UIFC_SC_RXRCV_BIT = 6;

	// Flag bit positions
	localparam int UIFC_FLG_RXERR = 0;
	localparam int UIFC_FLG_RXACT = 1;
	localparam int UIFC_FLG_CRC16 = 2;
	localparam int UIFC_FLG_J = 3;
	localparam int UIFC_FLG_K = 4;
	localparam int UIFC_FLG_SE0 = 5;
	localparam int UIFC_FLG_TOKEN = 6;

	// Reset values
	localparam logic [2:0] UIFC_RST_OPMODE = 3'h1;
	localparam logic UIFC_RST_TERM = 1'b1;
	localparam logic UIFC_RST_XCVR = 1'b1;
	localparam logic [3:0] UIFC_RST_SERIAL = 4'h2;

	// UTMI line-state encodings
	localparam logic [1:0] UIFC_LS_SE0 = 2'h0;
	localparam logic [1:0] UIFC_LS_J = 2'h1;
	localparam logic [1:0] UIFC_LS_K = 2'h2;

	// Register access request from the processor's peripheral port
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] periph;
		logic [7:0] addr;
		logic [31:0] wdata;
	} uifc_req_s;

	// Controls driven toward the transceiver
	typedef struct packed {
		logic [2:0] opmode;
		logic termselect;
		logic xcvrselect;
		logic ext_vbus_ind_sel;
		logic ext_vbus_drive;
		logic chrg_vbus;
		logic dischrg_vbus;
		logic dm_pulldown;
		logic dp_pulldown;
		logic id_pullup;
		logic tx_se0;
		logic tx_data;
		logic tx_enable_n;
		logic fsls_serial;
	} uifc_phy_ctrl_s;

	// Status from the transceiver
	typedef struct packed {
		logic bvalid;
		logic id_gnd;
		logic host_disc;
		logic vbus_valid;
		logic sess_valid;
		logic sess_end;
		logic rx_rcv;
		logic rx_dm;
		logic rx_dp;
		logic rx_active;
		logic rx_error;
		logic [1:0] line_state;
	} uifc_phy_stat_s;

	// Packet-decoder events into the flag logic
	typedef struct packed {
		logic pkt_start;
		logic token_ok;
		logic [6:0] token_addr;
		logic crc16_fail;
	} uifc_pkt_evt_s;

endpackage

// ===== src/uifc_flag_cell.sv
// One monitor flag with selectable stickiness and write-one-to-clear
`timescale 1ns/100ps

module uifc_flag_cell
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic clear_all_in,
	input wire logic hold_in,
	input wire logic set_in,
	input wire logic track_in,
	input wire logic track_val_in,
	input wire logic pkt_start_in,
	input wire logic w1c_in,
	output logic flag_out
);

	// Flag update: a set beats a write-one or packet-start clear in the same cycle; reset and clear_all_in beat the set
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || clear_all_in)
		begin
			flag_out <= 1'b0;
		end
		else if (set_in)
		begin
			// Event or tracked level wins over a pending write-one or packet-start clear
			flag_out <= 1'b1;
		end
		else if (hold_in)
		begin
			// Sticky: only a software one clears it
			if (w1c_in)
			begin
				flag_out <= 1'b0;
			end
		end
		else if (track_in)
		begin
			// Normal: later change of the signal overwrites
			flag_out <= track_val_in;
		end
		else if (pkt_start_in || w1c_in)
		begin
			// Normal flags clear when the next packet begins
			flag_out <= 1'b0;
		end
	end

endmodule

// ===== src/uifc_top.sv
// Control and status registers of the USB interface module facing the transceiver
`timescale 1ns/100ps

module uifc_top
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire uifc_pkg::uifc_req_s req_in,
	input wire uifc_pkg::uifc_phy_stat_s phy_stat_in,
	input wire uifc_pkg::uifc_pkt_evt_s pkt_evt_in,
	output logic [31:0] rdata_out,
	output logic rvalid_out,
	output logic access_err_out,
	output uifc_pkg::uifc_phy_ctrl_s phy_ctrl_out,
	output logic [7:0] modes_out,
	output logic token_pass_out,
	output logic [uifc_pkg::UIFC_PORTS-1:0] flag_port_out
);

	// Request qualified by peripheral number
	logic sel;
	logic wr_en;
	logic rd_en;
	// Module soft reset pulse from a write to offset zero
	logic soft_rst;
	// Writable registers
	logic [7:0] modes;
	logic [6:0] dev_addr;
	logic [4:0] func_ctrl;
	logic [7:0] otg_ctrl;
	logic [3:0] serial_ctrl;
	logic [6:0] hold_mask;
	logic [31:0] port_masks;
	logic [31:0] frame_num;
	logic [31:0] ep_mark;
	logic [31:0] otg_fmask;
	logic [31:0] power_sig;
	logic [31:0] phy_misc;
	// Flags and their per-bit drive terms
	logic [6:0] flags;
	logic [6:0] flag_set;
	logic [6:0] flag_track;
	logic [6:0] flag_val;
	logic [6:0] flag_w1c;
	// Previous line state, used to see a change of the monitored levels
	logic [1:0] prev_ls;
	logic prev_rx_act;
	logic prev_rx_err;
	logic ls_chg;
	// Token accepted through the address filter
	logic token_match;
	// Read mux result
	logic [31:0] next_rdata;
	logic next_err;

	// Only peripheral 1 answers; width is fixed at a whole 32-bit word
	assign sel = (req_in.periph == uifc_pkg::UIFC_PERIPH_NUM);
	assign wr_en = sel && req_in.wr;
	assign rd_en = sel && req_in.rd;
	assign soft_rst = wr_en && (req_in.addr == uifc_pkg::UIFC_OFS_SOFT_RESET);

	// Mode-control enables, reserved bit 3 masked off
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || soft_rst)
		begin
			modes <= 8'h00;
		end
		else if (wr_en && req_in.addr == uifc_pkg::UIFC_OFS_MODES)
		begin
			modes <= req_in.wdata[7:0] & uifc_pkg::UIFC_MODES_WMASK;
		end
	end

	// Device address held for the token filter
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || soft_rst)
		begin
			dev_addr <= 7'h00;
		end
		else if (wr_en && req_in.addr == uifc_pkg::UIFC_OFS_DEV_ADDR)
		begin
			// Software writes the assigned address after enumeration
			dev_addr <= req_in.wdata[6:0];
		end
	end

	// Functional control; each field resets to one
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || soft_rst)
		begin
			func_ctrl <= {uifc_pkg::UIFC_RST_OPMODE, uifc_pkg::UIFC_RST_TERM,
				uifc_pkg::UIFC_RST_XCVR};
		end
		else if (wr_en && req_in.addr == uifc_pkg::UIFC_OFS_FUNC_CTRL)
		begin
			func_ctrl <= req_in.wdata[4:0];
		end
	end

	// On-the-go drive controls, bit 5 reserved
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || soft_rst)
		begin
			otg_ctrl <= 8'h00;
		end
		else if (wr_en && req_in.addr == uifc_pkg::UIFC_OFS_OTG_CTRL)
		begin
			otg_ctrl <= req_in.wdata[7:0] & uifc_pkg::UIFC_OTG_WMASK;
		end
	end

	// Serial transmit controls; transmit enable is inactive (1) after reset
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || soft_rst)
		begin
			serial_ctrl <= uifc_pkg::UIFC_RST_SERIAL;
		end
		else if (wr_en && req_in.addr == uifc_pkg::UIFC_OFS_SERIAL)
		begin
			// Receive bits 6:4 are read-only, so only 3:0 are stored
			serial_ctrl <= req_in.wdata[3:0];
		end
	end

	// Stickiness mask
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || soft_rst)
		begin
			hold_mask <= 7'h00;
		end
		else if (wr_en && req_in.addr == uifc_pkg::UIFC_OFS_HOLD_MASK)
		begin
			hold_mask <= req_in.wdata[6:0];
		end
	end

	// Registers whose inner layouts this block does not act on, apart from the port masks that drive the flag ports
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || soft_rst)
		begin
			port_masks <= 32'h0000_0000;
			frame_num <= 32'h0000_0000;
			ep_mark <= 32'h0000_0000;
			otg_fmask <= 32'h0000_0000;
			power_sig <= 32'h0000_0000;
			phy_misc <= 32'h0000_0000;
		end
		else if (wr_en)
		begin
			// Address decode; reserved bits stay zero
			if (req_in.addr == uifc_pkg::UIFC_OFS_PORT_MASKS)
				port_masks <= req_in.wdata;
			else if (req_in.addr == uifc_pkg::UIFC_OFS_FRAME_NUM)
				frame_num <= req_in.wdata & uifc_pkg::UIFC_FRAME_WMASK;
			else if (req_in.addr == uifc_pkg::UIFC_OFS_EP_MARK)
				ep_mark <= req_in.wdata & uifc_pkg::UIFC_EP_MARK_WMASK;
			else if (req_in.addr == uifc_pkg::UIFC_OFS_OTG_FMASK)
				otg_fmask <= req_in.wdata;
			else if (req_in.addr == uifc_pkg::UIFC_OFS_POWER_SIG)
				power_sig <= req_in.wdata & uifc_pkg::UIFC_POWER_WMASK;
			else if (req_in.addr == uifc_pkg::UIFC_OFS_PHY_MISC)
				phy_misc <= req_in.wdata & uifc_pkg::UIFC_PHY_WMASK;
		end
	end

	// History of monitored levels for change detection
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || soft_rst)
		begin
			prev_ls <= uifc_pkg::UIFC_LS_J;
			prev_rx_act <= 1'b0;
			prev_rx_err <= 1'b0;
		end
		else
		begin
			prev_ls <= phy_stat_in.line_state;
			prev_rx_act <= phy_stat_in.rx_active;
			prev_rx_err <= phy_stat_in.rx_error;
		end
	end

	// Token filter: the address must match before the token is passed on
	assign token_match = pkt_evt_in.token_ok && (pkt_evt_in.token_addr == dev_addr);
	assign ls_chg = (phy_stat_in.line_state != prev_ls);

	// Per-flag set, track and value terms
	always_comb
	begin
		flag_set = 7'h00;
		flag_track = 7'h00;
		flag_val = 7'h00;
		// Token decoded with good CRC5, PID and matching address
		flag_set[uifc_pkg::UIFC_FLG_TOKEN] = token_match;
		// Line-state symbols, gated by the decoder enable
		if (modes[uifc_pkg::UIFC_MODE_LINE_DECODE] && ls_chg)
		begin
			flag_set[uifc_pkg::UIFC_FLG_SE0] = (phy_stat_in.line_state == uifc_pkg::UIFC_LS_SE0);
			flag_set[uifc_pkg::UIFC_FLG_K] = (phy_stat_in.line_state == uifc_pkg::UIFC_LS_K);
			flag_set[uifc_pkg::UIFC_FLG_J] = (phy_stat_in.line_state == uifc_pkg::UIFC_LS_J);
			// Non-sticky symbol flags are overwritten by the new state
			flag_track[uifc_pkg::UIFC_FLG_SE0] = 1'b1;
			flag_track[uifc_pkg::UIFC_FLG_K] = 1'b1;
			flag_track[uifc_pkg::UIFC_FLG_J] = 1'b1;
		end
		// Data packet CRC16 failure
		flag_set[uifc_pkg::UIFC_FLG_CRC16] = pkt_evt_in.crc16_fail;
		// Receive active and error follow their inputs
		flag_set[uifc_pkg::UIFC_FLG_RXACT] = phy_stat_in.rx_active && !prev_rx_act;
		flag_set[uifc_pkg::UIFC_FLG_RXERR] = phy_stat_in.rx_error && !prev_rx_err;
		flag_track[uifc_pkg::UIFC_FLG_RXACT] = (phy_stat_in.rx_active != prev_rx_act);
		flag_track[uifc_pkg::UIFC_FLG_RXERR] = (phy_stat_in.rx_error != prev_rx_err);
		flag_val[uifc_pkg::UIFC_FLG_RXACT] = phy_stat_in.rx_active;
		flag_val[uifc_pkg::UIFC_FLG_RXERR] = phy_stat_in.rx_error;
	end

	// Write-one-to-clear strobe per flag
	assign flag_w1c = (wr_en && req_in.addr == uifc_pkg::UIFC_OFS_FLAGS) ?
		req_in.wdata[6:0] : 7'h00;

	// One flag cell per flag bit
	genvar gi;
	generate
		for (gi = 0; gi < uifc_pkg::UIFC_FLAG_W; gi++)
		begin : g_flag
			uifc_flag_cell u_cell
			(
				.clk_in(clk_in),
				.rstn_in(rstn_in),
				.clear_all_in(soft_rst),
				.hold_in(hold_mask[gi]),
				.set_in(flag_set[gi]),
				.track_in(flag_track[gi]),
				.track_val_in(flag_val[gi]),
				.pkt_start_in(pkt_evt_in.pkt_start),
				.w1c_in(flag_w1c[gi]),
				.flag_out(flags[gi])
			);
		end
	endgenerate

	// Flag ports: any selected flag high drives the port high
	generate
		for (gi = 0; gi < uifc_pkg::UIFC_PORTS; gi++)
		begin : g_port
			assign flag_port_out[gi] = |(port_masks[gi*8 +: 7] & flags);
		end
	endgenerate

	// Read mux; unmapped offsets read zero and raise the access error
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		// Write-only reset, and packet records kept by the decoder outside, read zero
		if (req_in.addr == uifc_pkg::UIFC_OFS_SOFT_RESET ||
			req_in.addr == uifc_pkg::UIFC_OFS_LAST_PID ||
			req_in.addr == uifc_pkg::UIFC_OFS_LAST_EP)
			next_rdata = 32'h0000_0000;
		else if (req_in.addr == uifc_pkg::UIFC_OFS_MODES)
			next_rdata = {24'h00_0000, modes};
		else if (req_in.addr == uifc_pkg::UIFC_OFS_DEV_ADDR)
			next_rdata = {25'h000_0000, dev_addr};
		else if (req_in.addr == uifc_pkg::UIFC_OFS_FUNC_CTRL)
			next_rdata = {27'h000_0000, func_ctrl};
		else if (req_in.addr == uifc_pkg::UIFC_OFS_OTG_CTRL)
			next_rdata = {24'h00_0000, otg_ctrl};
		else if (req_in.addr == uifc_pkg::UIFC_OFS_OTG_STATUS)
			next_rdata = {26'h000_0000, phy_stat_in.bvalid, phy_stat_in.id_gnd,
				phy_stat_in.host_disc, phy_stat_in.vbus_valid,
				phy_stat_in.sess_valid, phy_stat_in.sess_end}; // Live, no storage
		else if (req_in.addr == uifc_pkg::UIFC_OFS_SERIAL)
			next_rdata = {25'h000_0000, phy_stat_in.rx_rcv, phy_stat_in.rx_dm,
				phy_stat_in.rx_dp, serial_ctrl}; // Receive lines in 6:4
		else if (req_in.addr == uifc_pkg::UIFC_OFS_FLAGS)
			next_rdata = {25'h000_0000, flags};
		else if (req_in.addr == uifc_pkg::UIFC_OFS_HOLD_MASK)
			next_rdata = {25'h000_0000, hold_mask};
		else if (req_in.addr == uifc_pkg::UIFC_OFS_PORT_MASKS)
			next_rdata = port_masks;
		else if (req_in.addr == uifc_pkg::UIFC_OFS_FRAME_NUM)
			next_rdata = frame_num;
		else if (req_in.addr == uifc_pkg::UIFC_OFS_EP_MARK)
			next_rdata = ep_mark;
		else if (req_in.addr == uifc_pkg::UIFC_OFS_OTG_FMASK)
			next_rdata = otg_fmask;
		else if (req_in.addr == uifc_pkg::UIFC_OFS_POWER_SIG)
			next_rdata = power_sig;
		else if (req_in.addr == uifc_pkg::UIFC_OFS_PHY_MISC)
			next_rdata = phy_misc;
		else
			next_err = 1'b1; // Unmapped offset
	end

	// Registered read answer, one cycle after the request
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			rdata_out <= 32'h0000_0000;
			rvalid_out <= 1'b0;
			access_err_out <= 1'b0;
		end
		else
		begin
			rdata_out <= rd_en ? next_rdata : 32'h0000_0000;
			rvalid_out <= rd_en;
			access_err_out <= (rd_en || wr_en) && next_err;
		end
	end

	// Transceiver controls straight from their registers
	always_comb
	begin
		phy_ctrl_out.opmode = func_ctrl[4:2];
		phy_ctrl_out.termselect = func_ctrl[uifc_pkg::UIFC_FC_TERM_BIT];
		phy_ctrl_out.xcvrselect = func_ctrl[uifc_pkg::UIFC_FC_XCVR_BIT];
		phy_ctrl_out.ext_vbus_ind_sel = otg_ctrl[7];
		phy_ctrl_out.ext_vbus_drive = otg_ctrl[6];
		phy_ctrl_out.chrg_vbus = otg_ctrl[4];
		phy_ctrl_out.dischrg_vbus = otg_ctrl[3];
		phy_ctrl_out.dm_pulldown = otg_ctrl[2];
		phy_ctrl_out.dp_pulldown = otg_ctrl[1];
		phy_ctrl_out.id_pullup = otg_ctrl[0];
		phy_ctrl_out.tx_se0 = serial_ctrl[uifc_pkg::UIFC_SC_TXSE0_BIT];
		phy_ctrl_out.tx_data = serial_ctrl[uifc_pkg::UIFC_SC_TXDAT_BIT];
		phy_ctrl_out.tx_enable_n = serial_ctrl[uifc_pkg::UIFC_SC_TXEN_N_BIT];
		phy_ctrl_out.fsls_serial = serial_ctrl[uifc_pkg::UIFC_SC_FSLS_BIT];
	end

	// Mode enables and filtered token indication to the token engine
	assign modes_out = modes;
	assign token_pass_out = token_match;

endmodule

// ===== sim/uifc_checker.sv
// Assertion checker on the ports of the USB interface control block
`timescale 1ns/100ps

module uifc_checker
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire uifc_pkg::uifc_req_s req_in,
	input wire uifc_pkg::uifc_phy_stat_s phy_stat_in,
	input wire uifc_pkg::uifc_pkt_evt_s pkt_evt_in,
	input wire logic [31:0] rdata_out,
	input wire logic rvalid_out,
	input wire logic access_err_out,
	input wire uifc_pkg::uifc_phy_ctrl_s phy_ctrl_out,
	input wire logic [7:0] modes_out,
	input wire logic token_pass_out,
	input wire logic [uifc_pkg::UIFC_PORTS-1:0] flag_port_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	// Requests that select this peripheral
	logic sel_wr;
	logic sel_rd;
	assign sel_wr = req_in.wr && (req_in.periph == uifc_pkg::UIFC_PERIPH_NUM);
	assign sel_rd = req_in.rd && (req_in.periph == uifc_pkg::UIFC_PERIPH_NUM);

	read_answer_a: assert property (sel_rd |=> rvalid_out)
		else $error("read not answered");
	idle_quiet_a: assert property (!sel_rd |=> !rvalid_out && rdata_out == 32'h0)
		else $error("read data without a read");
	// Pattern 3802 is opmode 1, term 1, xcvr 1, transmit enable off
	soft_reset_a: assert property (sel_wr && req_in.addr == 8'h00 |=>
		modes_out == 8'h00 && phy_ctrl_out == 16'h3802 && flag_port_out == '0)
		else $error("soft reset left state behind");
	modes_write_a: assert property (sel_wr && req_in.addr == 8'h04 |=>
		modes_out == ($past(req_in.wdata[7:0]) & uifc_pkg::UIFC_MODES_WMASK))
		else $error("mode enables wrong after write");
	func_write_a: assert property (sel_wr && req_in.addr == 8'h0C |=>
		{phy_ctrl_out.opmode, phy_ctrl_out.termselect, phy_ctrl_out.xcvrselect}
		== $past(req_in.wdata[4:0]))
		else $error("function controls wrong after write");
	otg_write_a: assert property (sel_wr && req_in.addr == 8'h10 |=>
		phy_ctrl_out[10:4] == {$past(req_in.wdata[7:6]), $past(req_in.wdata[4:0])})
		else $error("otg controls wrong after write");
	serial_write_a: assert property (sel_wr && req_in.addr == 8'h18 |=>
		phy_ctrl_out[3:0] == $past(req_in.wdata[3:0]))
		else $error("transmit controls wrong after write");
	// Struct bits 12:7 are the six otg status levels, 6:4 the receive lines
	otg_read_a: assert property (sel_rd && req_in.addr == 8'h14 |=>
		rdata_out == {26'h0, $past(phy_stat_in[12:7])})
		else $error("otg status read wrong");
	serial_read_a: assert property (sel_rd && req_in.addr == 8'h18 |=>
		rdata_out[6:4] == $past(phy_stat_in[6:4]) && rdata_out[31:7] == 25'h0)
		else $error("receive lines read wrong");
	token_gate_a: assert property (!pkt_evt_in.token_ok |-> !token_pass_out)
		else $error("token passed without a token");
	unmapped_err_a: assert property (sel_rd && req_in.addr == 8'h44 |=> access_err_out)
		else $error("unmapped access not flagged");
endmodule

// ===== sim/uifc_phy_model.sv
// Behavioural transceiver model feeding status levels to the block
`timescale 1ns/100ps

module uifc_phy_model
(
	input wire logic clk_in,
	input wire uifc_pkg::uifc_phy_ctrl_s phy_ctrl_in,
	input wire logic [5:0] otg_set_in,
	input wire logic [2:0] rx_lines_in,
	input wire logic [1:0] line_in,
	input wire logic rx_active_in,
	input wire logic rx_error_in,
	output uifc_pkg::uifc_phy_stat_s phy_stat_out
);
	// Levels move one edge after the command, like a registered transceiver output
	always_ff @(posedge clk_in)
	begin
		phy_stat_out <= {otg_set_in, rx_lines_in, rx_active_in, rx_error_in, line_in};
		// Driving SE0 shows up on our own line state
		if (!phy_ctrl_in.tx_enable_n && phy_ctrl_in.tx_se0)
			phy_stat_out.line_state <= uifc_pkg::UIFC_LS_SE0;
	end
endmodule

// ===== sim/tb.sv
// Self-checking testbench of the USB interface control block
`timescale 1ns/100ps

module tb;
	logic clk_in;
	logic rstn_in;
	uifc_pkg::uifc_req_s req;
	uifc_pkg::uifc_pkt_evt_s evt;
	uifc_pkg::uifc_phy_stat_s stat;
	uifc_pkg::uifc_phy_ctrl_s ctrl;
	logic [31:0] rdata;
	logic rvalid;
	logic aerr;
	logic [7:0] modes;
	logic tpass;
	logic [3:0] fport;
	logic [5:0] otg_set;
	logic [2:0] rx_lines;
	logic [1:0] line;
	logic rx_act;
	logic rx_err;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	// Offsets, reset values and all-ones readback of the writable registers
	logic [7:0] ofs [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24};
	logic [31:0] rst_v [8] = '{32'h0, 32'h0, 32'h7, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};
	logic [31:0] one_v [8] = '{32'hF7, 32'h7F, 32'h1F, 32'hDF, 32'hF, 0, 32'h7F, 32'hFFFFFFFF};

	uifc_top DUT (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .phy_stat_in(stat),
		.pkt_evt_in(evt), .rdata_out(rdata), .rvalid_out(rvalid), .access_err_out(aerr),
		.phy_ctrl_out(ctrl), .modes_out(modes), .token_pass_out(tpass), .flag_port_out(fport));
	uifc_phy_model pm (.clk_in(clk_in), .phy_ctrl_in(ctrl), .otg_set_in(otg_set),
		.rx_lines_in(rx_lines), .line_in(line), .rx_active_in(rx_act), .rx_error_in(rx_err),
		.phy_stat_out(stat));

	// Clock, 50 ns period
	initial
	begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// Compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// One request, held for exactly the edge that takes it
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		req <= '{wr: w, rd: !w, periph: 8'h01, addr: a, wdata: d};
		@(posedge clk_in);
		req <= '0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk("read valid", {31'h0, rvalid}, 32'h1);
		chk($sformatf("register %h", a), rdata, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask

	// Token from the decoder; the pass strobe is combinational
	task automatic tok(input logic [6:0] a, input logic exp);
		@(posedge clk_in);
		evt <= '{pkt_start: 1'b0, token_ok: 1'b1, token_addr: a, crc16_fail: 1'b0};
		#1;
		chk("token pass", {31'h0, tpass}, {31'h0, exp});
		@(posedge clk_in);
		evt <= '0;
	endtask

	task automatic pulse(input uifc_pkg::uifc_pkt_evt_s e);
		@(posedge clk_in);
		evt <= e;
		@(posedge clk_in);
		evt <= '0;
	endtask

	// Transceiver levels, then time for model and flag to follow
	task automatic phy(input logic [1:0] l, input logic a, input logic e);
		@(posedge clk_in);
		line <= l;
		rx_act <= a;
		rx_err <= e;
		repeat (3) @(posedge clk_in);
	endtask

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Cut a hang short well past the expected run length
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	initial
	begin
		rstn_in = 1'b0;
		req = '0;
		evt = '0;
		otg_set = 6'h00;
		rx_lines = 3'h0;
		line = uifc_pkg::UIFC_LS_J;
		rx_act = 1'b0;
		rx_err = 1'b0;
		repeat (20) @(posedge clk_in);
		rstn_in <= 1'b1;
		foreach (ofs[i]) rd(ofs[i], rst_v[i]);
		chk("reset controls", {16'h0, ctrl}, 32'h3802);
		// All ones: reserved bits stay zero, controls follow
		foreach (ofs[i])
		begin
			wr(ofs[i], 32'hFFFFFFFF);
			rd(ofs[i], one_v[i]);
		end
		chk("full controls", {16'h0, ctrl}, 32'hFFFF);
		chk("full modes", {24'h0, modes}, 32'hF7);
		wr(8'h14, 32'hFFFFFFFF);
		rd(8'h14, 32'h0);
		acc(1'b0, 8'h44, 32'h0);
		chk("unmapped", {31'h0, aerr}, 32'h1);
		// Any data to offset zero restores everything
		wr(8'h00, 32'h5A5A0001);
		foreach (ofs[i]) rd(ofs[i], rst_v[i]);
		chk("soft reset controls", {16'h0, ctrl}, 32'h3802);
		// Live status levels
		otg_set <= 6'h2A;
		rx_lines <= 3'h5;
		phy(uifc_pkg::UIFC_LS_J, 1'b0, 1'b0);
		rd(8'h14, 32'h2A);
		rd(8'h18, 32'h52);
		// Address filter, token flag, clearing and holding
		wr(8'h08, 32'h15);
		tok(7'h14, 1'b0);
		rd(8'h1C, 32'h0);
		tok(7'h15, 1'b1);
		rd(8'h1C, 32'h40);
		pulse(10'h200);
		rd(8'h1C, 32'h0);
		wr(8'h20, 32'h40);
		tok(7'h15, 1'b1);
		pulse(10'h200);
		rd(8'h1C, 32'h40);
		wr(8'h1C, 32'h40);
		rd(8'h1C, 32'h0);
		// Line-state flags, including our own SE0 transmit
		wr(8'h04, 32'h04);
		phy(uifc_pkg::UIFC_LS_K, 1'b0, 1'b0);
		rd(8'h1C, 32'h10);
		phy(uifc_pkg::UIFC_LS_J, 1'b0, 1'b0);
		rd(8'h1C, 32'h08);
		// Loopback takes one edge in the model and one more into the flag
		wr(8'h18, 32'h08);
		repeat (2) @(posedge clk_in);
		rd(8'h1C, 32'h20);
		wr(8'h18, 32'h02);
		repeat (2) @(posedge clk_in);
		rd(8'h1C, 32'h08);
		wr(8'h04, 32'h00);
		phy(uifc_pkg::UIFC_LS_K, 1'b0, 1'b0);
		rd(8'h1C, 32'h08);
		// Data CRC and receive levels
		pulse(10'h200);
		pulse(10'h001);
		phy(uifc_pkg::UIFC_LS_K, 1'b1, 1'b1);
		rd(8'h1C, 32'h07);
		phy(uifc_pkg::UIFC_LS_K, 1'b0, 1'b1);
		rd(8'h1C, 32'h05);
		// Port masks over the flags
		wr(8'h24, 32'h00000401);
		chk("flag ports", {28'h0, fport}, 32'h3);
		wr(8'h1C, 32'h7F);
		chk("flag ports cleared", {28'h0, fport}, 32'h0);
		give_verdict();
	end
endmodule

bind uifc_top uifc_checker chk_i (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req_in),
	.phy_stat_in(phy_stat_in), .pkt_evt_in(pkt_evt_in), .rdata_out(rdata_out),
	.rvalid_out(rvalid_out), .access_err_out(access_err_out), .phy_ctrl_out(phy_ctrl_out),
	.modes_out(modes_out), .token_pass_out(token_pass_out), .flag_port_out(flag_port_out));
